/* common/rtcsw_params.svh */
// constants of the two-wire clock/memory slave port and its master
`ifndef RTCSW_PARAMS_SVH
`define RTCSW_PARAMS_SVH
`define RTCSW_ID_ARRAY 4'ha
`define RTCSW_ID_CLK 4'hd
`define RTCSW_SEL 3'h7
`define RTCSW_ARR_MASK 4'hf
`define RTCSW_CLK_MASK 4'h7
`define RTCSW_WDAY0 16'h0006
`define RTCSW_WDAY1 16'h000e
`define RTCSW_RTC_SECT 13'h0006
`define RTCSW_RTC_LEN 5'h08
`define RTCSW_SR_ADDR 16'h003f
`define RTCSW_WEL_1 8'h02
`define RTCSW_WEL_2 8'h06
`define RTCSW_ARR_DEPTH 512
`define RTCSW_CLK_DEPTH 64
`define RTCSW_CLK_MHZ 100
`define RTCSW_TPROG_US 12000
`define RTCSW_TPROG_CYC (`RTCSW_TPROG_US * `RTCSW_CLK_MHZ)
`define RTCSW_SCL_KHZ 400
`define RTCSW_QTR_CYC ((`RTCSW_CLK_MHZ * 1000 + 4 * `RTCSW_SCL_KHZ - 1) / (4 * `RTCSW_SCL_KHZ))
`define RTCSW_FIFO_DEPTH 32
`endif

/* common/rtcsw_pkg.sv */
// state types of both ends
package rtcsw_pkg;
  typedef enum logic [5:0] {
    RS_IDLE = 6'h01, RS_DEV = 6'h02, RS_AHI = 6'h04,
    RS_ALO = 6'h08, RS_WR = 6'h10, RS_RD = 6'h20
  } rtcsw_sstate_e;
  typedef enum logic [5:0] {
    HS_IDLE = 6'h01, HS_START = 6'h02, HS_LOAD = 6'h04,
    HS_TX = 6'h08, HS_RX = 6'h10, HS_STOP = 6'h20
  } rtcsw_hstate_e;
  typedef enum logic [4:0] {
    ST_DEVW = 5'h01, ST_AHI = 5'h02, ST_ALO = 5'h04,
    ST_DATA = 5'h08, ST_DEVR = 5'h10
  } rtcsw_step_e;
endpackage

/* common/rtcsw_if.sv */
// two-wire link between master and slave, open-drain data line
`timescale 1ns/100ps
`default_nettype none
interface rtcsw_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface
`default_nettype wire

/* logic/rtcsw_slave.sv */
// slave end: bus conditions, address decode, page write and programming
`timescale 1ns/100ps
`default_nettype none
`include "rtcsw_params.svh"
module rtcsw_slave #(
  parameter int ARR_DEPTH = `RTCSW_ARR_DEPTH,
  parameter int CLK_DEPTH = `RTCSW_CLK_DEPTH,
  parameter int PROG_CYC = `RTCSW_TPROG_CYC
) (
  input wire logic clock,
  input wire logic rst,
  rtcsw_if.slave bus,
  input wire logic prot_en,
  input wire logic [15:0] prot_base,
  input wire logic [15:0] peek_addr,
  output logic [7:0] peek_data,
  output logic busy
);
  import rtcsw_pkg::*;
  localparam int AW = $clog2(ARR_DEPTH);
  localparam int CW = $clog2(CLK_DEPTH);
  localparam int PW = $clog2(PROG_CYC + 1);

  rtcsw_sstate_e state;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic sda_oe;
  logic space;
  logic [15:0] addr;
  logic [15:0] faddr;
  logic [4:0] wcount;
  logic [PW-1:0] prog_cnt;
  logic [4:0] prog_idx;
  logic wspace;
  logic [7:0] pbuf [16];
  logic [15:0] pval;
  logic [7:0] arr [ARR_DEPTH];
  logic [7:0] ccs [CLK_DEPTH];

  // line conditions, seen after the two-stage synchronisers
  wire scl_rise = scl_s[1] & ~scl_q;
  wire scl_fall = ~scl_s[1] & scl_q;
  wire start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1] & ~busy;
  wire stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  wire active = (state != RS_IDLE) & ~start_det & ~stop_det;
  wire byte_end = active & scl_fall & (bitcnt == 4'h8);
  wire ninth_end = active & scl_fall & (bitcnt == 4'h9);
  wire wr_take = byte_end & (state == RS_WR);
  wire alo_take = byte_end & (state == RS_ALO);

  // slave address decode
  wire id_arr = shreg[7:4] == `RTCSW_ID_ARRAY;
  wire id_clk = shreg[7:4] == `RTCSW_ID_CLK;
  wire dev_hit = (id_arr | id_clk) & (shreg[3:1] == `RTCSW_SEL);

  // page wrap of the write pointer
  wire [3:0] pmask = space ? `RTCSW_CLK_MASK : `RTCSW_ARR_MASK;
  wire [15:0] pmask16 = {12'h000, pmask};
  wire [15:0] addr_p1 = addr + 16'h0001;
  wire [15:0] addr_wrap = (addr & ~pmask16) | (addr_p1 & pmask16);
  wire [7:0] rd_byte = space ? ccs[addr[CW-1:0]] : arr[addr[AW-1:0]];

  // decision taken at the stop that ends a write
  wire wr_prot = ~space & prot_en & (faddr >= prot_base);
  wire wday_one = space & (wcount == 5'h01) &
    ((faddr == `RTCSW_WDAY0) | (faddr == `RTCSW_WDAY1));
  wire rtc_part = space & (faddr[15:3] == `RTCSW_RTC_SECT) &
    (wcount < `RTCSW_RTC_LEN);
  wire clean_end = (state == RS_WR) & (wcount != 5'h00) & (bitcnt <= 4'h1);
  // status register is volatile: unlock writes start no programming cycle
  wire sr_wr = space & (faddr == `RTCSW_SR_ADDR);
  wire commit = stop_det & clean_end & ~wr_prot & ~wday_one & ~rtc_part & ~sr_wr;
  wire prog_wr = busy & ~prog_idx[4] & pval[prog_idx[3:0]];
  wire [15:0] prog_addr = {faddr[15:4], prog_idx[3:0]};

  assign busy = prog_cnt != '0;
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe & ~busy;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= RS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      space <= 1'b0;
      addr <= 16'h0000;
      faddr <= 16'h0000;
      wcount <= 5'h00;
    end else if (start_det) begin
      state <= RS_DEV;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= RS_IDLE;
      sda_oe <= 1'b0;
    end else if (active & scl_rise) begin
      if (bitcnt < 4'h8) begin
        if (state != RS_RD) begin
          shreg <= {shreg[6:0], sda_s[1]};
        end
        bitcnt <= bitcnt + 4'h1;
      end else begin
        bitcnt <= 4'h9;
        if (state == RS_RD) begin
          shreg[0] <= ~sda_s[1];
        end
      end
    end else if (byte_end) begin
      case (state)
        RS_DEV: begin
          if (dev_hit) begin
            sda_oe <= 1'b1;
            space <= id_clk;
            state <= shreg[0] ? RS_RD : RS_AHI;
          end else begin
            state <= RS_IDLE;
          end
        end
        RS_AHI: begin
          addr[15:8] <= shreg;
          sda_oe <= 1'b1;
          state <= RS_ALO;
        end
        RS_ALO: begin
          addr[7:0] <= shreg;
          faddr <= {addr[15:8], shreg};
          wcount <= 5'h00;
          sda_oe <= 1'b1;
          state <= RS_WR;
        end
        RS_WR: begin
          sda_oe <= 1'b1;
          addr <= addr_wrap;
          if (wcount != 5'h1f) begin
            wcount <= wcount + 5'h01;
          end
        end
        RS_RD: begin
          sda_oe <= 1'b0;
          shreg[0] <= 1'b1;
        end
        default: begin
          state <= RS_IDLE;
        end
      endcase
    end else if (ninth_end) begin
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
      if (state == RS_RD) begin
        if (shreg[0]) begin
          shreg <= rd_byte;
          sda_oe <= ~rd_byte[7];
          addr <= addr_p1;
        end else begin
          state <= RS_IDLE;
        end
      end
    end else if (active & scl_fall & (state == RS_RD) & (bitcnt != 4'h0)) begin
      sda_oe <= ~shreg[6];
      shreg <= {shreg[6:0], 1'b0};
    end
  end

  // programming cycle: one buffered byte per clock, then the busy wait
  always_ff @(posedge clock) begin
    if (rst) begin
      prog_cnt <= '0;
      prog_idx <= 5'h00;
      wspace <= 1'b0;
    end else if (commit) begin
      prog_cnt <= PW'(PROG_CYC);
      prog_idx <= 5'h00;
      wspace <= space;
    end else if (busy) begin
      prog_cnt <= prog_cnt - PW'(1);
      if (~prog_idx[4]) begin
        prog_idx <= prog_idx + 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst | alo_take) begin
      pval <= 16'h0000;
    end else if (wr_take) begin
      pval[addr[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_take) begin
      pbuf[addr[3:0]] <= shreg;
    end
  end

  always_ff @(posedge clock) begin
    if (prog_wr & wspace) begin
      ccs[prog_addr[CW-1:0]] <= pbuf[prog_idx[3:0]];
    end
    if (prog_wr & ~wspace) begin
      arr[prog_addr[AW-1:0]] <= pbuf[prog_idx[3:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      peek_data <= 8'h00;
    end else begin
      peek_data <= arr[peek_addr[AW-1:0]];
    end
  end
endmodule
`default_nettype wire

/* logic/rtcsw_master.sv */
// master end: command sequencer, bit engine and write-data fifo
`timescale 1ns/100ps
`default_nettype none
`include "rtcsw_params.svh"
module rtcsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RTCSW_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid = wptr != rptr;
  assign out_data = mem[rptr[AW-1:0]];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= wptr + (AW+1)'(push);
      rptr <= rptr + (AW+1)'(pop);
    end
  end
endmodule

module rtcsw_master #(
  parameter int QTR_CYC = `RTCSW_QTR_CYC
) (
  input wire logic clock,
  input wire logic rst,
  rtcsw_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_rw,
  input wire logic cmd_space,
  input wire logic [15:0] cmd_addr,
  input wire logic [4:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack
);
  import rtcsw_pkg::*;
  localparam int QW = $clog2(QTR_CYC + 1);
  rtcsw_hstate_e state;
  rtcsw_step_e step;
  logic [QW-1:0] qcnt;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [4:0] count;
  logic [1:0] pre;
  logic [1:0] sda_s;
  logic smp;
  logic scl;
  logic oe;
  logic c_rw;
  logic c_space;
  logic [15:0] c_addr;
  logic [4:0] c_len;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;

  rtcsw_fifo #(.WIDTH(8), .DEPTH(`RTCSW_FIFO_DEPTH)) rtcsw_fifo_inst (
    .clock(clock),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // status-register unlock writes precede a clock-space write of nonzero length
  wire in_pre = pre != 2'h0;
  wire e_rw = in_pre ? 1'b0 : c_rw;
  wire e_space = in_pre | c_space;
  wire [15:0] e_addr = in_pre ? `RTCSW_SR_ADDR : c_addr;
  wire [4:0] e_len = in_pre ? 5'h01 : c_len;
  wire [3:0] id = e_space ? `RTCSW_ID_CLK : `RTCSW_ID_ARRAY;
  wire [7:0] pre_byte = (pre == 2'h2) ? `RTCSW_WEL_1 : `RTCSW_WEL_2;
  wire need_fifo = (step == ST_DATA) & ~in_pre;
  wire [7:0] tx_byte = (step == ST_DEVW) ? {id, `RTCSW_SEL, 1'b0} :
    (step == ST_DEVR) ? {id, `RTCSW_SEL, 1'b1} :
    (step == ST_AHI) ? e_addr[15:8] :
    (step == ST_ALO) ? e_addr[7:0] :
    in_pre ? pre_byte : f_data;
  wire load_ok = (state == HS_LOAD) & (~need_fifo | f_valid);
  wire tick = (state != HS_IDLE) & (state != HS_LOAD) & (qcnt == QW'(QTR_CYC - 1));
  wire last = (count + 5'h01) == e_len;
  wire q3 = tick & (q == 2'h3);

  assign f_ready = load_ok & need_fifo;
  assign cmd_ready = state == HS_IDLE;
  assign bus.scl = scl;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = oe;

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_s <= 2'h3;
      qcnt <= '0;
    end else begin
      sda_s <= {sda_s[0], bus.sda};
      qcnt <= (tick | ~(state != HS_IDLE && state != HS_LOAD)) ? '0 : qcnt + QW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= HS_IDLE;
      step <= ST_DEVW;
      q <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      count <= 5'h00;
      pre <= 2'h0;
      smp <= 1'b1;
      scl <= 1'b1;
      oe <= 1'b0;
      c_rw <= 1'b0;
      c_space <= 1'b0;
      c_addr <= 16'h0000;
      c_len <= 5'h00;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (tick) begin
        q <= q + 2'h1;
      end
      case (state)
        HS_IDLE: begin
          if (cmd_valid) begin
            c_rw <= cmd_rw;
            c_space <= cmd_space;
            c_addr <= cmd_addr;
            c_len <= cmd_len;
            pre <= (cmd_space & ~cmd_rw & (cmd_len != 5'h00)) ? 2'h2 : 2'h0;
            nack <= 1'b0;
            step <= ST_DEVW;
            count <= 5'h00;
            q <= 2'h0;
            state <= HS_START;
          end
        end
        HS_START: begin
          if (tick) begin
            case (q)
              2'h0: oe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: oe <= 1'b1;
              default: begin
                scl <= 1'b0;
                state <= HS_LOAD;
              end
            endcase
          end
        end
        HS_LOAD: begin
          if (load_ok) begin
            shreg <= tx_byte;
            bitn <= 4'h0;
            state <= HS_TX;
          end
        end
        HS_TX: begin
          if (tick) begin
            case (q)
              2'h0: oe <= (bitn != 4'h8) & ~shreg[7];
              2'h1: scl <= 1'b1;
              2'h2: smp <= sda_s[1];
              default: begin
                scl <= 1'b0;
                shreg <= {shreg[6:0], 1'b0};
                bitn <= bitn + 4'h1;
              end
            endcase
          end
          if (q3 & (bitn == 4'h8)) begin
            if (smp) begin
              nack <= 1'b1;
              state <= HS_STOP;
            end else begin
              case (step)
                ST_DEVW: begin
                  step <= ST_AHI;
                  state <= ((e_len == 5'h00) & ~e_rw) ? HS_STOP : HS_LOAD;
                end
                ST_AHI: begin
                  step <= ST_ALO;
                  state <= HS_LOAD;
                end
                ST_ALO: begin
                  step <= e_rw ? ST_DEVR : ST_DATA;
                  state <= e_rw ? HS_START : HS_LOAD;
                end
                ST_DATA: begin
                  count <= count + 5'h01;
                  state <= last ? HS_STOP : HS_LOAD;
                end
                default: begin
                  count <= 5'h00;
                  bitn <= 4'h0;
                  state <= HS_RX;
                end
              endcase
            end
          end
        end
        HS_RX: begin
          if (tick) begin
            case (q)
              2'h0: oe <= (bitn == 4'h8) & ~last;
              2'h1: scl <= 1'b1;
              2'h2: smp <= sda_s[1];
              default: begin
                scl <= 1'b0;
                if (bitn != 4'h8) begin
                  shreg <= {shreg[6:0], smp};
                end
                bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
              end
            endcase
          end
          if (q3 & (bitn == 4'h8)) begin
            rd_data <= shreg;
            rd_valid <= 1'b1;
            count <= count + 5'h01;
            if (last) begin
              state <= HS_STOP;
            end
          end
        end
        HS_STOP: begin
          if (tick) begin
            case (q)
              2'h0: oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: oe <= 1'b0;
              default: begin
                if (in_pre & ~nack) begin
                  pre <= pre - 2'h1;
                  step <= ST_DEVW;
                  count <= 5'h00;
                  state <= HS_START;
                end else begin
                  done <= 1'b1;
                  state <= HS_IDLE;
                end
              end
            endcase
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* tb/rtcsw_checker.sv */
// concurrent checks on the two-wire link between master and slave ends
`timescale 1ns/100ps
`default_nettype none
module rtcsw_checker #(
  parameter int QTR_CYC = 4,
  parameter int PROG_CYC = 200
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda,
  input wire logic busy
);
  logic sda_q;
  logic scl_q;
  logic in_frame;
  logic [7:0] hi_cnt;
  logic [7:0] stop_age;
  logic [31:0] busy_len;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  always_ff @(posedge clock) begin
    sda_q <= sda;
    scl_q <= scl;
  end
  always_ff @(posedge clock) begin
    if (rst || !scl) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hff) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (rst || stop_w) begin
      in_frame <= 1'b0;
    end else if (start_w) begin
      in_frame <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      stop_age <= 8'hff;
    end else if (stop_w) begin
      stop_age <= 8'h00;
    end else if (stop_age != 8'hff) begin
      stop_age <= stop_age + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (rst || !busy) begin
      busy_len <= 32'h0;
    end else begin
      busy_len <= busy_len + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_hold8;
    sda_s_oe [*8];
  endsequence
  sequence s_scl_up;
    $rose(scl) && sda_s_oe;
  endsequence
  sequence s_stop_m;
    scl && $past(scl) && $fell(sda_m_oe);
  endsequence
  property p_drive_low;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("slave data changed with clock high");
  property p_ack_hold;
    $rose(sda_s_oe) |-> s_hold8;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("slave drive shorter than a bit");
  property p_hold_high;
    s_scl_up |-> sda_s_oe [*7];
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("slave drive dropped in high phase");
  property p_busy_quiet;
    busy |-> !sda_s_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("slave drives while programming");
  property p_scl_high;
    $fell(scl) |-> int'(hi_cnt) >= 2 * QTR_CYC;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  property p_stop_released;
    s_stop_m |-> !sda_s_oe;
  endproperty
  a_stop_released: assert property (p_stop_released) else $error("stop while slave drives");
  property p_frame;
    sda_s_oe |-> in_frame;
  endproperty
  a_frame: assert property (p_frame) else $error("slave drives outside a frame");
  property p_prog_len;
    $fell(busy) |-> busy_len == 32'(PROG_CYC);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming length wrong");
  property p_prog_after_stop;
    $rose(busy) |-> stop_age <= 8'h08;
  endproperty
  a_prog_after_stop: assert property (p_prog_after_stop) else $error("programming without stop");
  property p_line_level;
    sda == !((sda_s_oe && !sda_s_o) || (sda_m_oe && !sda_m_o));
  endproperty
  a_line_level: assert property (p_line_level) else $error("data line level wrong");
endmodule
`default_nettype wire

/* tb/rtc_serial_slave_write_port_tb.sv */
// testbench joining master and slave ends over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module rtc_serial_slave_write_port_tb;
  import rtcsw_pkg::*;
  localparam int QTR = 4;
  localparam int PROG = 200;
  logic clock, rst, cmd_valid, cmd_ready, cmd_rw, cmd_space, wr_valid, wr_ready;
  logic rd_valid, done, nack, prot_en, busy;
  logic [15:0] cmd_addr, prot_base, peek_addr;
  logic [4:0] cmd_len;
  logic [7:0] wr_data, rd_data, peek_data;
  logic [7:0] rxq[$];
  logic [7:0] pg[16];
  int err_total;
  int checks;
  always #5 clock = ~clock;
  rtcsw_if lnk();
  rtcsw_master #(.QTR_CYC(QTR)) rtcsw_master_inst (.clock(clock), .rst(rst), .bus(lnk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_space(cmd_space),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  rtcsw_slave #(.PROG_CYC(PROG)) rtcsw_slave_inst (.clock(clock), .rst(rst), .bus(lnk),
    .prot_en(prot_en), .prot_base(prot_base), .peek_addr(peek_addr),
    .peek_data(peek_data), .busy(busy));
  rtcsw_checker #(.QTR_CYC(QTR), .PROG_CYC(PROG)) rtcsw_checker_inst (.clock(clock),
    .rst(rst), .scl(lnk.scl), .sda_m_o(lnk.sda_m_o), .sda_m_oe(lnk.sda_m_oe),
    .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe), .sda(lnk.sda), .busy(busy));
  always @(negedge clock) begin
    if (rd_valid === 1'b1) rxq.push_back(rd_data);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fill(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      wr_data = b + 8'(i);
      wr_valid = 1'b1;
      chk(16'(wr_ready), 16'(i < 32));
      @(negedge clock);
    end
    wr_valid = 1'b0;
  endtask
  task automatic cmd(input logic rw, input logic sp, input logic [15:0] a, input logic [4:0] n);
    int k;
    rxq.delete();
    cmd_valid = 1'b1;
    cmd_rw = rw;
    cmd_space = sp;
    cmd_addr = a;
    cmd_len = n;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50) begin
      k++;
      @(negedge clock);
    end
    chk(16'(cmd_ready), 16'h0001);
    @(negedge clock);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      k++;
      @(negedge clock);
    end
    chk(16'(done), 16'h0001);
  endtask
  task automatic idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      k++;
      @(negedge clock);
    end
    chk(16'(busy), 16'h0000);
  endtask
  task automatic prog(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clock);
      if (busy === 1'b1) seen = 1'b1;
    end
    idle();
    chk(16'(seen), 16'(exp));
  endtask
  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    peek_addr = a;
    @(negedge clock);
    chk(16'(peek_data), 16'(e));
  endtask
  initial begin
    #800us;
    err_total++;
    end_of_test();
  end
  initial begin
    {clock, rst, cmd_valid, cmd_rw, cmd_space, wr_valid, prot_en} = 7'h20;
    {cmd_addr, cmd_len, wr_data, peek_addr} = 45'h0;
    prot_base = 16'h0100;
    err_total = 0;
    checks = 0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk(16'({cmd_ready, busy, nack}), 16'h0004);
    fill(1, 8'h5a);
    cmd(1'b0, 1'b0, 16'h0005, 5'h01);
    chk(16'(nack), 16'h0000);
    cmd(1'b0, 1'b0, 16'h0005, 5'h00);
    chk(16'(nack), 16'h0001);
    idle();
    cmd(1'b0, 1'b0, 16'h0005, 5'h00);
    chk(16'(nack), 16'h0000);
    peek(16'h0005, 8'h5a);
    cmd(1'b1, 1'b0, 16'h0005, 5'h01);
    chk(16'(rxq[0]), 16'h005a);
    fill(33, 8'h80);
    for (int i = 0; i < 18; i++) pg[(10 + i) % 16] = 8'h80 + 8'(i);
    cmd(1'b0, 1'b0, 16'h001a, 5'h12);
    prog(1'b1);
    for (int j = 0; j < 16; j++) peek(16'h0010 + 16'(j), pg[j]);
    cmd(1'b0, 1'b0, 16'h0040, 5'h0e);
    prog(1'b1);
    for (int j = 0; j < 14; j++) peek(16'h0040 + 16'(j), 8'h92 + 8'(j));
    cmd(1'b1, 1'b0, 16'h001c, 5'h04);
    for (int i = 0; i < 4; i++) chk(16'(rxq[i]), 16'(pg[12 + i]));
    fill(1, 8'h11);
    cmd(1'b0, 1'b0, 16'h0150, 5'h01);
    prog(1'b1);
    prot_en = 1'b1;
    fill(1, 8'h33);
    cmd(1'b0, 1'b0, 16'h0150, 5'h01);
    chk(16'(nack), 16'h0000);
    prog(1'b0);
    peek(16'h0150, 8'h11);
    cmd(1'b0, 1'b0, 16'h0150, 5'h00);
    chk(16'(nack), 16'h0000);
    prot_en = 1'b0;
    fill(1, 8'h44);
    cmd(1'b0, 1'b1, 16'h0006, 5'h01);
    chk(16'(nack), 16'h0000);
    prog(1'b0);
    fill(1, 8'h55);
    cmd(1'b0, 1'b1, 16'h0030, 5'h01);
    prog(1'b0);
    fill(8, 8'h60);
    cmd(1'b0, 1'b1, 16'h0030, 5'h08);
    prog(1'b1);
    cmd(1'b1, 1'b1, 16'h0030, 5'h08);
    for (int i = 0; i < 8; i++) chk(16'(rxq[i]), 16'h0060 + 16'(i));
    fill(3, 8'h71);
    cmd(1'b0, 1'b1, 16'h000e, 5'h03);
    prog(1'b1);
    cmd(1'b1, 1'b1, 16'h000e, 5'h02);
    chk(16'({rxq[0], rxq[1]}), 16'h7172);
    cmd(1'b1, 1'b1, 16'h0008, 5'h01);
    chk(16'(rxq[0]), 16'h0073);
    end_of_test();
  end
endmodule
`default_nettype wire
